// [include/uart_fmt_pkg.sv]
// Contract
// - enable bit turns queues on, gates upper bits
// - enable change empties both queues
// - receive flush bit empties receive queue, self-clears
// - transmit flush bit empties transmit queue, self-clears
// - trigger field picks 1, 4, 8, 14 characters
// - length field picks 5 to 8 bits
// - stop bit one, two, or one and half
// - parity on adds and checks parity bit
// - parity kind odd, even, stick one, zero
// - break bit holds transmit line low
// - latch access bit redirects shared locations
// - receive level flag follows fill versus trigger
package uart_fmt_pkg;

   // ---------------------------------------------
   // register byte addresses
   // ---------------------------------------------
   localparam logic [31:0] ADDR_DATA = 32'h40008000;
   localparam logic [31:0] ADDR_DIVHI = 32'h40008004;
   localparam logic [31:0] ADDR_QCTRL = 32'h40008008;
   localparam logic [31:0] ADDR_LFMT = 32'h4000800C;
   localparam logic [31:0] ADDR_STAT = 32'h40008014;

   // ---------------------------------------------
   // field positions
   // ---------------------------------------------
   localparam int QC_EN = 0;
   localparam int QC_RXFL = 1;
   localparam int QC_TXFL = 2;
   localparam int QC_TRIG_LO = 6;
   localparam int QC_TRIG_HI = 7;
   localparam int LF_WLS_LO = 0;
   localparam int LF_WLS_HI = 1;
   localparam int LF_STOP = 2;
   localparam int LF_PEN = 3;
   localparam int LF_PK_LO = 4;
   localparam int LF_PK_HI = 5;
   localparam int LF_BRK = 6;
   localparam int LF_DIVISOR_LATCH_ACCESS = 7;

   // ---------------------------------------------
   // reset values and encodings
   // ---------------------------------------------
   localparam logic [7:0] LFMT_RESET = 8'h00;
   localparam logic [1:0] TRIG_RESET = 2'h0;
   localparam logic [15:0] DIV_RESET = 16'h0001;
   localparam logic [1:0] PK_ODD = 2'h0;
   localparam logic [1:0] PK_EVEN = 2'h1;
   localparam logic [1:0] PK_ONE = 2'h2;
   localparam logic [1:0] WLS_5 = 2'h0;
   localparam logic [3:0] WORD_MIN = 4'h5;
   localparam logic [3:0] WORD_MAX = 4'h8;
   localparam logic [4:0] TRIG_L0 = 5'h01;
   localparam logic [4:0] TRIG_L1 = 5'h04;
   localparam logic [4:0] TRIG_L2 = 5'h08;
   localparam logic [4:0] TRIG_L3 = 5'h0E;
   localparam logic [3:0] HALVES_1 = 4'h2;
   localparam logic [3:0] HALVES_15 = 4'h3;
   localparam logic [3:0] HALVES_2 = 4'h4;

   // ---------------------------------------------
   // queue geometry
   // ---------------------------------------------
   localparam logic [4:0] QDEPTH = 5'h10;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} txState_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rxState_t;

endpackage

// [hdl/two_entry_buffer.sv]
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   input wire logic flush,
   // filling side
   input wire logic inValid,
   output logic inReady,
   input wire logic [7:0] inData,
   // draining side
   output logic outValid,
   input wire logic outReady,
   output logic [7:0] outData
);

   logic [7:0] slot_ff [2];
   logic [1:0] count_ff;
   logic push;
   logic pop;

   // handshakes straight from the fill count
   assign inReady = (count_ff != 2'h2);
   assign outValid = (count_ff != 2'h0);
   assign outData = slot_ff[0];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   // occupancy; flush drops both words
   always_ff @(posedge clock) begin
      if (!nrst || flush) begin
         count_ff <= 2'h0;
      end else begin
         count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
      end
   end

   // slot 0 always holds the oldest word
   always_ff @(posedge clock) begin
      if (!nrst) begin
         slot_ff[0] <= 8'h00;
         slot_ff[1] <= 8'h00;
      end else begin
         if (pop) begin
            slot_ff[0] <= (push && count_ff == 2'h1) ? inData : slot_ff[1];
         end else if (push && count_ff == 2'h0) begin
            slot_ff[0] <= inData;
         end
         if (push && (count_ff == 2'h2 - {1'b0, pop} || (count_ff == 2'h1 && !pop))) begin
            slot_ff[1] <= inData;
         end
      end
   end

endmodule // two_entry_buffer
`default_nettype wire

// [hdl/uart_fifo_line_format.sv]
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_line_format (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // register port
   input wire logic [31:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   // serial line
   input wire logic rxdPin,
   output logic txdPin,
   // receive level flag
   output logic receiveDataAvailableIrq
);

   // -------------------------------------------------
   // register state and decode
   // -------------------------------------------------
   logic queueEnable_ff;
   logic [1:0] rxTrig_ff;
   logic [7:0] lineFmt_ff;
   logic [15:0] divisor_ff;
   logic wrData, wrDivLo, wrDivHi, wrQctrl, wrLfmt, rdData, rdStat;
   logic divisor_latch_access, enToggle, rxFlush, txFlush;
   logic [1:0] word_length_select, pkind;
   logic [3:0] dataBits, stopHalves;

   assign divisor_latch_access = lineFmt_ff[uart_fmt_pkg::LF_DIVISOR_LATCH_ACCESS];
   assign word_length_select = lineFmt_ff[uart_fmt_pkg::LF_WLS_HI:uart_fmt_pkg::LF_WLS_LO];
   assign pkind = lineFmt_ff[uart_fmt_pkg::LF_PK_HI:uart_fmt_pkg::LF_PK_LO];
   assign dataBits = uart_fmt_pkg::WORD_MIN + {2'h0, word_length_select};

   // stop length counted in half bit times
   always_comb begin
      if (!lineFmt_ff[uart_fmt_pkg::LF_STOP]) begin
         stopHalves = uart_fmt_pkg::HALVES_1;
      end else if (word_length_select == uart_fmt_pkg::WLS_5) begin
         stopHalves = uart_fmt_pkg::HALVES_15;
      end else begin
         stopHalves = uart_fmt_pkg::HALVES_2;
      end
   end

   // address decode; shared locations steered by latch access
   always_comb begin
      wrData = 1'b0;
      wrDivLo = 1'b0;
      wrDivHi = 1'b0;
      wrQctrl = 1'b0;
      wrLfmt = 1'b0;
      rdData = 1'b0;
      rdStat = 1'b0;
      if (regAddr == uart_fmt_pkg::ADDR_DATA) begin
         wrData = regWrite & ~divisor_latch_access;
         wrDivLo = regWrite & divisor_latch_access;
         rdData = regRead & ~divisor_latch_access;
      end else if (regAddr == uart_fmt_pkg::ADDR_DIVHI) begin
         wrDivHi = regWrite & divisor_latch_access;
      end else if (regAddr == uart_fmt_pkg::ADDR_QCTRL) begin
         wrQctrl = regWrite;
      end else if (regAddr == uart_fmt_pkg::ADDR_LFMT) begin
         wrLfmt = regWrite;
      end else if (regAddr == uart_fmt_pkg::ADDR_STAT) begin
         rdStat = regRead;
      end
   end

   // flush pulses; the flush bits are never stored, so they self-clear
   assign enToggle = wrQctrl && (regWrData[uart_fmt_pkg::QC_EN] != queueEnable_ff);
   assign rxFlush = enToggle | (wrQctrl & regWrData[uart_fmt_pkg::QC_EN] & regWrData[uart_fmt_pkg::QC_RXFL]);
   assign txFlush = enToggle | (wrQctrl & regWrData[uart_fmt_pkg::QC_EN] & regWrData[uart_fmt_pkg::QC_TXFL]);

   // queue control: upper bits only land while enable is written high
   always_ff @(posedge clock) begin
      if (!nrst) begin
         queueEnable_ff <= 1'b0;
         rxTrig_ff <= uart_fmt_pkg::TRIG_RESET;
      end else if (wrQctrl) begin
         queueEnable_ff <= regWrData[uart_fmt_pkg::QC_EN];
         if (regWrData[uart_fmt_pkg::QC_EN]) begin
            rxTrig_ff <= regWrData[uart_fmt_pkg::QC_TRIG_HI:uart_fmt_pkg::QC_TRIG_LO];
         end
      end
   end

   // line format and divisor latches
   always_ff @(posedge clock) begin
      if (!nrst) begin
         lineFmt_ff <= uart_fmt_pkg::LFMT_RESET;
         divisor_ff <= uart_fmt_pkg::DIV_RESET;
      end else begin
         if (wrLfmt) lineFmt_ff <= regWrData[7:0];
         if (wrDivLo) divisor_ff[7:0] <= regWrData[7:0];
         if (wrDivHi) divisor_ff[15:8] <= regWrData[7:0];
      end
   end

   // -------------------------------------------------
   // parity and bit timing
   // -------------------------------------------------
   function automatic logic parityOf(input logic [7:0] d, input logic [1:0] len, input logic [1:0] kind);
      logic x;
      x = ^(d & (8'hFF >> (2'h3 - len)));
      case (kind)
         uart_fmt_pkg::PK_ODD: parityOf = ~x;
         uart_fmt_pkg::PK_EVEN: parityOf = x;
         uart_fmt_pkg::PK_ONE: parityOf = 1'b1;
         default: parityOf = 1'b0;
      endcase
   endfunction

   logic [15:0] halfPeriod, txDiv_ff, rxDiv_ff;
   logic txTick, rxTick, rxRestart;
   // a divisor of 0 or 1 still yields a one-cycle half bit
   assign halfPeriod = (divisor_ff[15:1] == 15'h0000) ? 16'h0001 : {1'b0, divisor_ff[15:1]};
   assign txTick = (txDiv_ff >= halfPeriod - 16'h0001);
   assign rxTick = (rxDiv_ff >= halfPeriod - 16'h0001);

   // transmit divider free runs; receive divider realigns on each start edge
   always_ff @(posedge clock) begin
      if (!nrst) begin
         txDiv_ff <= 16'h0000;
         rxDiv_ff <= 16'h0000;
      end else begin
         txDiv_ff <= txTick ? 16'h0000 : txDiv_ff + 16'h0001;
         rxDiv_ff <= (rxTick || rxRestart) ? 16'h0000 : rxDiv_ff + 16'h0001;
      end
   end

   // -------------------------------------------------
   // transmit queue and buffer
   // -------------------------------------------------
   logic [7:0] txMem [16];
   logic [3:0] txWp_ff, txRp_ff;
   logic [4:0] txCnt_ff;
   logic txPush, txPop, bufInReady, bufValid, bufReady;
   logic [7:0] bufData;

   // characters written while the queues are off are dropped
   assign txPush = wrData & queueEnable_ff & (txCnt_ff != uart_fmt_pkg::QDEPTH);
   assign txPop = (txCnt_ff != 5'h00) & bufInReady;

   always_ff @(posedge clock) begin
      if (!nrst || txFlush) begin
         txWp_ff <= 4'h0;
         txRp_ff <= 4'h0;
         txCnt_ff <= 5'h00;
      end else begin
         if (txPush) txWp_ff <= txWp_ff + 4'h1;
         if (txPop) txRp_ff <= txRp_ff + 4'h1;
         txCnt_ff <= txCnt_ff + {4'h0, txPush} - {4'h0, txPop};
      end
   end

   always_ff @(posedge clock) begin
      if (txPush) txMem[txWp_ff] <= regWrData[7:0];
   end

   // two words of slack so a busy serializer never loses one
   two_entry_buffer txBuf (
      .clock(clock),
      .nrst(nrst),
      .flush(txFlush),
      .inValid(txCnt_ff != 5'h00),
      .inReady(bufInReady),
      .inData(txMem[txRp_ff]),
      .outValid(bufValid),
      .outReady(bufReady),
      .outData(bufData)
   );

   // -------------------------------------------------
   // serializer
   // -------------------------------------------------
   uart_fmt_pkg::txState_t txState_ff;
   logic [7:0] txShift_ff;
   logic [3:0] txBitCnt_ff, txHalf_ff, lastHalf;
   logic txLine_ff, txPar_ff, txdPin_ff;

   assign bufReady = (txState_ff == uart_fmt_pkg::TX_IDLE) & txTick;
   assign lastHalf = (txState_ff == uart_fmt_pkg::TX_STOP) ? stopHalves - 4'h1 : 4'h1;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         txState_ff <= uart_fmt_pkg::TX_IDLE;
         txShift_ff <= 8'h00;
         txBitCnt_ff <= 4'h0;
         txHalf_ff <= 4'h0;
         txLine_ff <= 1'b1;
         txPar_ff <= 1'b0;
      end else if (txState_ff == uart_fmt_pkg::TX_IDLE) begin
         if (bufReady && bufValid) begin
            txShift_ff <= bufData;
            txPar_ff <= parityOf(bufData, word_length_select, pkind);
            txLine_ff <= 1'b0;
            txHalf_ff <= 4'h0;
            txState_ff <= uart_fmt_pkg::TX_START;
         end
      end else if (txTick) begin
         if (txHalf_ff < lastHalf) begin
            txHalf_ff <= txHalf_ff + 4'h1;
         end else begin
            txHalf_ff <= 4'h0;
            case (txState_ff)
               uart_fmt_pkg::TX_START: begin
                  txLine_ff <= txShift_ff[0];
                  txShift_ff <= {1'b0, txShift_ff[7:1]};
                  txBitCnt_ff <= 4'h1;
                  txState_ff <= uart_fmt_pkg::TX_DATA;
               end
               uart_fmt_pkg::TX_DATA: begin
                  if (txBitCnt_ff >= dataBits) begin
                     if (lineFmt_ff[uart_fmt_pkg::LF_PEN]) begin
                        txLine_ff <= txPar_ff;
                        txState_ff <= uart_fmt_pkg::TX_PARITY;
                     end else begin
                        txLine_ff <= 1'b1;
                        txState_ff <= uart_fmt_pkg::TX_STOP;
                     end
                  end else begin
                     txLine_ff <= txShift_ff[0];
                     txShift_ff <= {1'b0, txShift_ff[7:1]};
                     txBitCnt_ff <= txBitCnt_ff + 4'h1;
                  end
               end
               uart_fmt_pkg::TX_PARITY: begin
                  txLine_ff <= 1'b1;
                  txState_ff <= uart_fmt_pkg::TX_STOP;
               end
               default: txState_ff <= uart_fmt_pkg::TX_IDLE;
            endcase
         end
      end
   end

   // break overrides whatever the serializer drives
   always_ff @(posedge clock) begin
      if (!nrst) txdPin_ff <= 1'b1;
      else txdPin_ff <= txLine_ff & ~lineFmt_ff[uart_fmt_pkg::LF_BRK];
   end
   assign txdPin = txdPin_ff;

   // -------------------------------------------------
   // deserializer
   // -------------------------------------------------
   uart_fmt_pkg::rxState_t rxState_ff;
   logic rxSync1_ff, rxSync2_ff, rxHalf_ff, rxParBit_ff, rxDone_ff, rxFrame_ff;
   logic [7:0] rxShift_ff, rxWord;
   logic [3:0] rxBitCnt_ff;

   // pin passes two flops before anything looks at it
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rxSync1_ff <= 1'b1;
         rxSync2_ff <= 1'b1;
      end else begin
         rxSync1_ff <= rxdPin;
         rxSync2_ff <= rxSync1_ff;
      end
   end

   assign rxRestart = (rxState_ff == uart_fmt_pkg::RX_IDLE);
   assign rxWord = rxShift_ff >> (uart_fmt_pkg::WORD_MAX - dataBits);

   // samples at mid bit; a start shorter than half a bit is a glitch
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rxState_ff <= uart_fmt_pkg::RX_IDLE;
         rxShift_ff <= 8'h00;
         rxBitCnt_ff <= 4'h0;
         rxHalf_ff <= 1'b0;
         rxParBit_ff <= 1'b0;
         rxDone_ff <= 1'b0;
         rxFrame_ff <= 1'b0;
      end else begin
         rxDone_ff <= 1'b0;
         case (rxState_ff)
            uart_fmt_pkg::RX_IDLE: begin
               if (!rxSync2_ff) rxState_ff <= uart_fmt_pkg::RX_START;
               rxHalf_ff <= 1'b0;
               rxBitCnt_ff <= 4'h0;
            end
            uart_fmt_pkg::RX_START: begin
               if (rxTick) begin
                  rxState_ff <= rxSync2_ff ? uart_fmt_pkg::RX_IDLE : uart_fmt_pkg::RX_DATA;
               end
            end
            default: begin
               if (rxTick) begin
                  rxHalf_ff <= ~rxHalf_ff;
                  if (rxHalf_ff) begin
                     case (rxState_ff)
                        uart_fmt_pkg::RX_DATA: begin
                           rxShift_ff <= {rxSync2_ff, rxShift_ff[7:1]};
                           rxBitCnt_ff <= rxBitCnt_ff + 4'h1;
                           if (rxBitCnt_ff + 4'h1 >= dataBits) begin
                              rxState_ff <= lineFmt_ff[uart_fmt_pkg::LF_PEN] ?
                                 uart_fmt_pkg::RX_PARITY : uart_fmt_pkg::RX_STOP;
                           end
                        end
                        uart_fmt_pkg::RX_PARITY: begin
                           rxParBit_ff <= rxSync2_ff;
                           rxState_ff <= uart_fmt_pkg::RX_STOP;
                        end
                        default: begin
                           rxFrame_ff <= ~rxSync2_ff;
                           rxDone_ff <= 1'b1;
                           rxState_ff <= uart_fmt_pkg::RX_IDLE;
                        end
                     endcase
                  end
               end
            end
         endcase
      end
   end

   // -------------------------------------------------
   // receive queue, level flag and status
   // -------------------------------------------------
   logic [7:0] rxMem [16];
   logic [3:0] rxWp_ff, rxRp_ff;
   logic [4:0] rxCnt_ff, rxThresh;
   logic rxPush, rxPop, rxAvail_ff, parErr_ff, overrun_ff, frameErr_ff, parBad;

   assign rxPush = rxDone_ff & queueEnable_ff & (rxCnt_ff != uart_fmt_pkg::QDEPTH);
   assign rxPop = rdData & (rxCnt_ff != 5'h00);
   assign parBad = rxDone_ff & lineFmt_ff[uart_fmt_pkg::LF_PEN] & (rxParBit_ff != parityOf(rxWord, word_length_select, pkind));

   always_ff @(posedge clock) begin
      if (!nrst || rxFlush) begin
         rxWp_ff <= 4'h0;
         rxRp_ff <= 4'h0;
         rxCnt_ff <= 5'h00;
      end else begin
         if (rxPush) rxWp_ff <= rxWp_ff + 4'h1;
         if (rxPop) rxRp_ff <= rxRp_ff + 4'h1;
         rxCnt_ff <= rxCnt_ff + {4'h0, rxPush} - {4'h0, rxPop};
      end
   end

   always_ff @(posedge clock) begin
      if (rxPush) rxMem[rxWp_ff] <= rxWord;
   end

   // trigger code to character count
   always_comb begin
      case (rxTrig_ff)
         2'h0: rxThresh = uart_fmt_pkg::TRIG_L0;
         2'h1: rxThresh = uart_fmt_pkg::TRIG_L1;
         2'h2: rxThresh = uart_fmt_pkg::TRIG_L2;
         default: rxThresh = uart_fmt_pkg::TRIG_L3;
      endcase
   end

   // level flag and sticky errors; a new error beats a status read
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rxAvail_ff <= 1'b0;
         parErr_ff <= 1'b0;
         overrun_ff <= 1'b0;
         frameErr_ff <= 1'b0;
      end else begin
         rxAvail_ff <= (rxCnt_ff >= rxThresh);
         parErr_ff <= parBad | (parErr_ff & ~rdStat);
         overrun_ff <= (rxDone_ff & ~rxPush) | (overrun_ff & ~rdStat);
         frameErr_ff <= (rxDone_ff & rxFrame_ff) | (frameErr_ff & ~rdStat);
      end
   end
   assign receiveDataAvailableIrq = rxAvail_ff;

   // read data registered, valid the cycle after the strobe
   always_ff @(posedge clock) begin
      if (!nrst || !regRead) begin
         regRdData <= 32'h00000000;
      end else if (regAddr == uart_fmt_pkg::ADDR_DATA) begin
         regRdData <= divisor_latch_access ? {24'h000000, divisor_ff[7:0]} :
            {24'h000000, (rxCnt_ff != 5'h00) ? rxMem[rxRp_ff] : 8'h00};
      end else if (regAddr == uart_fmt_pkg::ADDR_DIVHI) begin
         regRdData <= divisor_latch_access ? {24'h000000, divisor_ff[15:8]} : 32'h00000000;
      end else if (regAddr == uart_fmt_pkg::ADDR_LFMT) begin
         regRdData <= {24'h000000, lineFmt_ff};
      end else if (regAddr == uart_fmt_pkg::ADDR_STAT) begin
         regRdData <= {17'h00000, txState_ff != uart_fmt_pkg::TX_IDLE, frameErr_ff, overrun_ff,
            parErr_ff, rxAvail_ff, txCnt_ff, rxCnt_ff};
      end else begin
         regRdData <= 32'h00000000;
      end
   end

   // -------------------------------------------------
   // checks
   // -------------------------------------------------
   a_upper_gated: assert property (@(posedge clock) disable iff (!nrst)
      wrQctrl && !regWrData[0] |=> $stable(rxTrig_ff)) else $error("trigger changed with enable low");
   a_toggle_flush: assert property (@(posedge clock) disable iff (!nrst)
      enToggle |=> rxCnt_ff == 5'h00 && txCnt_ff == 5'h00) else $error("enable change left data");
   a_rx_flush: assert property (@(posedge clock) disable iff (!nrst)
      wrQctrl && regWrData[0] && regWrData[1] |=> rxCnt_ff == 5'h00) else $error("rx flush failed");
   a_tx_flush: assert property (@(posedge clock) disable iff (!nrst)
      wrQctrl && regWrData[0] && regWrData[2] |=> txCnt_ff == 5'h00) else $error("tx flush failed");
   a_level_flag: assert property (@(posedge clock) disable iff (!nrst)
      ##1 rxAvail_ff == ($past(rxCnt_ff) >= $past(rxThresh))) else $error("level flag wrong");
   a_word_length: assert property (@(posedge clock) disable iff (!nrst)
      txState_ff == uart_fmt_pkg::TX_DATA |-> txBitCnt_ff <= dataBits) else $error("too many data bits");
   a_stop_length: assert property (@(posedge clock) disable iff (!nrst)
      txState_ff == uart_fmt_pkg::TX_STOP |-> txHalf_ff < stopHalves) else $error("stop too long");
   a_parity_bit: assert property (@(posedge clock) disable iff (!nrst)
      txState_ff == uart_fmt_pkg::TX_DATA ##1 txState_ff == uart_fmt_pkg::TX_PARITY |-> txLine_ff == txPar_ff)
      else $error("parity bit wrong");
   a_no_parity: assert property (@(posedge clock) disable iff (!nrst)
      txState_ff == uart_fmt_pkg::TX_DATA && !lineFmt_ff[3] |=> txState_ff != uart_fmt_pkg::TX_PARITY)
      else $error("parity sent while off");
   a_break_low: assert property (@(posedge clock) disable iff (!nrst)
      lineFmt_ff[6] |=> !txdPin) else $error("break not driven");
   a_latch_read: assert property (@(posedge clock) disable iff (!nrst)
      regRead && regAddr == uart_fmt_pkg::ADDR_DATA && divisor_latch_access |=> regRdData == {24'h000000, $past(divisor_ff[7:0])})
      else $error("latch read wrong");

endmodule // uart_fifo_line_format
`default_nettype wire

// [testbench/serial_peer.sv]
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------
// remote serial sender on the receive line
// -------------------------------------------
module serial_peer #(
   parameter int BITCLK = 4
) (
   // clock
   input wire logic clock,
   // serial line into the block
   output logic rxd
);
   // line idles high; a frame starts only from a clock edge
   initial rxd = 1'b1;
   // start, data lsb first, optional parity bit, then idle high
   task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic pb);
      int i;
      rxd <= 1'b0;
      repeat (BITCLK) @(posedge clock);
      for (i = 0; i < nb; i++) begin
         rxd <= d[i];
         repeat (BITCLK) @(posedge clock);
      end
      if (pe) begin
         rxd <= pb;
         repeat (BITCLK) @(posedge clock);
      end
      rxd <= 1'b1;
      repeat (2 * BITCLK) @(posedge clock);
   endtask
endmodule // serial_peer
`default_nettype wire

// [testbench/uart_fifo_line_format_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------
// bench for the line format and queue control
// -------------------------------------------
module uart_fifo_line_format_tb_top;
   logic clock = 1'b0, nrst = 1'b0, regWrite = 1'b0, regRead = 1'b0, rxdPin, txdPin, irq;
   logic [31:0] regAddr = 32'h0, regWrData = 32'h0, regRdData, rdv;
   int n_errors = 0, samples_checked = 0;
   always #5 clock = ~clock;
   serial_peer #(.BITCLK(4)) u_peer (.clock(clock), .rxd(rxdPin));
   uart_fifo_line_format u_dut (.clock(clock), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .rxdPin(rxdPin), .txdPin(txdPin),
      .receiveDataAvailableIrq(irq));
   task automatic finish_test;
      if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask
   // one-cycle strobes, launched right after an edge
   task automatic wr(input logic [31:0] a, d);
      @(posedge clock);
      regAddr <= a; regWrData <= d; regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   task automatic rdc(input logic [31:0] a, e);
      @(posedge clock);
      regAddr <= a; regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 rdv = regRdData;
      chk(rdv, e);
   endtask
   // divisor 4 gives a four-clock bit; sample mid-bit on the falling edge
   task automatic txchk(input logic [7:0] lf, d);
      int i, nb;
      logic [7:0] m;
      logic p;
      nb = 5 + lf[1:0];
      m = d & (8'hFF >> (8 - nb));
      case (lf[5:4])
         2'h0: p = ~^m;
         2'h1: p = ^m;
         2'h2: p = 1'b1;
         default: p = 1'b0;
      endcase
      wr(uart_fmt_pkg::ADDR_LFMT, {24'h0, lf});
      wr(uart_fmt_pkg::ADDR_DATA, {24'h0, d});
      i = 0;
      while (txdPin !== 1'b0 && i < 300) begin @(negedge clock); i++; end
      if (i == 300) begin n_errors++; finish_test; end
      repeat (2) @(negedge clock);
      for (i = 0; i < nb; i++) begin repeat (4) @(negedge clock); chk(txdPin, m[i]); end
      if (lf[3]) begin repeat (4) @(negedge clock); chk(txdPin, p); end
      repeat (4) @(negedge clock);
      chk(txdPin, 1'b1);
      repeat (8) @(negedge clock);
   endtask
   // hang guard
   initial begin
      repeat (60000) @(posedge clock);
      n_errors++;
      finish_test;
   end
   initial begin
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      rdc(uart_fmt_pkg::ADDR_LFMT, 32'h0);
      rdc(uart_fmt_pkg::ADDR_QCTRL, 32'h0);
      rdc(32'h40008020, 32'h0);
      wr(uart_fmt_pkg::ADDR_LFMT, 32'h5A);
      rdc(uart_fmt_pkg::ADDR_LFMT, 32'h5A);
      wr(uart_fmt_pkg::ADDR_LFMT, 32'h40);
      repeat (2) @(negedge clock);
      chk(txdPin, 1'b0);
      wr(uart_fmt_pkg::ADDR_LFMT, 32'h80);
      wr(uart_fmt_pkg::ADDR_DATA, 32'h04);
      wr(uart_fmt_pkg::ADDR_DIVHI, 32'h00);
      rdc(uart_fmt_pkg::ADDR_DATA, 32'h04);
      wr(uart_fmt_pkg::ADDR_LFMT, 32'h03);
      rdc(uart_fmt_pkg::ADDR_DIVHI, 32'h0);
      wr(uart_fmt_pkg::ADDR_QCTRL, 32'h41);
      txchk(8'h1B, 8'hA5);
      txchk(8'h0A, 8'h4E);
      txchk(8'h2D, 8'h33);
      txchk(8'h3C, 8'h77);
      txchk(8'h00, 8'h13);
      wr(uart_fmt_pkg::ADDR_LFMT, 32'h03);
      for (int k = 0; k < 4; k++) begin
         @(negedge clock);
         chk(irq, 1'b0);
         @(posedge clock);
         u_peer.send(8'h31 + k[7:0], 8, 1'b0, 1'b0);
         repeat (6) @(posedge clock);
      end
      #1 chk(irq, 1'b1);
      // four held characters sit below the 14 and 8 levels, then meet 4 again
      wr(uart_fmt_pkg::ADDR_QCTRL, 32'hC1);
      repeat (2) @(negedge clock);
      chk(irq, 1'b0);
      wr(uart_fmt_pkg::ADDR_QCTRL, 32'h81);
      repeat (2) @(negedge clock);
      chk(irq, 1'b0);
      wr(uart_fmt_pkg::ADDR_QCTRL, 32'h41);
      repeat (2) @(negedge clock);
      chk(irq, 1'b1);
      rdc(uart_fmt_pkg::ADDR_DATA, 32'h31);
      repeat (2) @(negedge clock);
      chk(irq, 1'b0);
      wr(uart_fmt_pkg::ADDR_QCTRL, 32'h03);
      rdc(uart_fmt_pkg::ADDR_STAT, 32'h0);
      // odd parity expected, even-count bit sent: parity error flagged
      wr(uart_fmt_pkg::ADDR_LFMT, 32'h0B);
      u_peer.send(8'h55, 8, 1'b1, 1'b0);
      repeat (6) @(posedge clock);
      rdc(uart_fmt_pkg::ADDR_STAT, 32'h0C01);
      wr(uart_fmt_pkg::ADDR_QCTRL, 32'h00);
      rdc(uart_fmt_pkg::ADDR_STAT, 32'h0);
      finish_test;
   end
endmodule // uart_fifo_line_format_tb_top
`default_nettype wire
